// [blp_pkg.sv]
package blp_pkg;
	// ==========================================
	// register map (byte addresses)
	localparam logic [3:0] BLP_OFF_BREAK_EXIT = 4'h0;
	localparam logic [3:0] BLP_OFF_RESET_CAUSE = 4'h4;
	localparam logic [3:0] BLP_OFF_BREAK_CLEAR = 4'h8;
	localparam logic [3:0] BLP_OFF_CONFIG = 4'hc;
	// ==========================================
	// field positions
	localparam int BLP_BIT_EXIT_FLAG = 1;
	localparam int BLP_BIT_CLEAR_EN = 7;
	localparam int BLP_BIT_WDOG_DIS = 0;
	localparam int BLP_BIT_SHORT_REC = 1;
	// reset cause order: low_voltage, bad_fetch, bad_opcode, watchdog, pin, power-on
	localparam int BLP_CAUSE_POR = 7;
	localparam int BLP_CAUSE_PIN = 6;
	localparam int BLP_CAUSE_WDOG = 5;
	localparam int BLP_CAUSE_OPC = 4;
	localparam int BLP_CAUSE_ADR = 3;
	localparam int BLP_CAUSE_LVD = 1;
	// ==========================================
	// reset values and timing
	localparam logic [7:0] BLP_RST_CAUSE = 8'h80;
	localparam logic [7:0] BLP_RST_CLEAR_CTRL = 8'h00;
	localparam logic [7:0] BLP_RST_CONFIG = 8'h00;
	localparam int BLP_REC_LONG_CYC = 4096;
	localparam int BLP_REC_SHORT_CYC = 32;
	localparam int BLP_CNT_W = 12;
	localparam logic [1:0] BLP_RESP_OKAY = 2'b00;
	localparam logic [1:0] BLP_RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {BLP_RUN, BLP_WAIT, BLP_STOP, BLP_RECOVER} blp_mode_t;
endpackage

// [blp_osc_if.sv]
`timescale 1ns/100ps
// oscillator-rate timing between the top and the system counter
interface blp_osc_if;
	logic osc_tick;
	logic hold_clr;
	logic [11:0] count;
	modport ctl (output osc_tick, output hold_clr, input count);
	modport cnt (input osc_tick, input hold_clr, output count);
endinterface : blp_osc_if

// [blp_sys_counter.sv]
`timescale 1ns/100ps
// ==========================================
// 12-bit system counter, advanced once per oscillator falling-edge tick
module blp_sys_counter (
	input wire logic clk_sys, // system clock
	input wire logic arst_n, // async reset, low
	blp_osc_if.cnt osc // tick, hold and count
);
	import blp_pkg::*;
	typedef struct packed {
		logic [BLP_CNT_W-1:0] cnt;
	} blp_cnt_st_t;
	blp_cnt_st_t st_r, st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (osc.hold_clr) begin
			st_nxt.cnt = '0;
		end else if (osc.osc_tick) begin
			st_nxt.cnt = st_r.cnt + 12'h001;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign osc.count = st_r.cnt;

	a_hold_clears: assert property (@(posedge clk_sys) disable iff (!arst_n)
		osc.hold_clr |=> (osc.count == 12'h000)) else $error("counter not held");
	a_tick_adds: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(osc.osc_tick && !osc.hold_clr) |=> (osc.count == $past(osc.count) + 12'h001))
		else $error("counter missed tick");
endmodule // blp_sys_counter

// [blp_break_lowpower.sv]
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/100ps
module blp_break_lowpower (
	input wire logic clk_sys, // 200 MHz system clock
	input wire logic arst_n, // async reset, low
	input wire logic osc_clk_pin, // oscillator clock, sampled
	input wire logic break_req, // break module request
	input wire logic wait_exec, // cpu executed wait, pulse
	input wire logic stop_exec, // cpu executed stop, pulse
	input wire logic irq_pending, // enabled module interrupt
	input wire logic rst_por, // power-on reset source, pulse
	input wire logic rst_pin, // external pin reset, pulse
	input wire logic rst_wdog, // watchdog reset, pulse
	input wire logic rst_opcode, // illegal opcode reset, pulse
	input wire logic rst_fetch, // unmapped fetch reset, pulse
	input wire logic rst_lvd, // low voltage reset, pulse
	input wire logic flag_clr_req, // module flag clear request
	input wire logic [31:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [31:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	output logic force_trap_vec, // fetch software_trap vector
	output logic in_break, // break state
	output logic flag_clr_allow, // modules may clear flags
	output logic cpu_clk_en, // cpu clock enable
	output logic bus_clk_en, // bus_clock_output enable
	output logic osc_clk_en, // oscillator_clock enable
	output logic periph_clk_en, // peripheral clock enable
	output logic clr_int_mask, // clear ccr interrupt mask, pulse
	output logic stack_start, // begin interrupt stacking, pulse
	output logic wdog_en, // watchdog enabled
	output logic sys_reset // internal reset, above interrupts
);
	import blp_pkg::*;

	localparam logic [11:0] REC_LONG_LAST = 12'(BLP_REC_LONG_CYC - 1);
	localparam logic [11:0] REC_SHORT_LAST = 12'(BLP_REC_SHORT_CYC - 1);

	// ==========================================
	// state
	typedef struct packed {
		logic [2:0] osc_sync;
		blp_mode_t mode;
		logic brk;
		logic exit_flag;
		logic [7:0] cause;
		logic clear_en;
		logic wdog_dis;
		logic short_rec;
		logic rec_irq;
		logic clr_mask;
		logic stack;
		logic reset_out;
		logic aw_got;
		logic w_got;
		logic [3:0] aw_addr;
		logic [31:0] wdata;
		logic wbyte;
		logic wr_en;
		logic bvalid;
		logic bad_wr;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} blp_state_t;
	blp_state_t st_r, st_nxt;

	blp_osc_if osc();
	blp_sys_counter u_cnt (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.osc(osc)
	);

	logic any_reset;
	logic wr_fire;
	logic rd_fire;
	logic [11:0] rec_last;
	logic [3:0] rd_off;
	logic [7:0] rd_byte;
	logic rd_ok;
	logic wr_ok;

	assign any_reset = rst_por | rst_pin | rst_wdog | rst_opcode | rst_fetch | rst_lvd;
	assign rec_last = st_r.short_rec ? REC_SHORT_LAST : REC_LONG_LAST;
	assign wr_fire = st_r.aw_got && st_r.w_got && !st_r.bvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign rd_off = s_axi_araddr[3:0];

	always_comb begin
		rd_ok = 1'b1;
		rd_byte = 8'h00;
		case (rd_off)
			BLP_OFF_BREAK_EXIT: rd_byte[BLP_BIT_EXIT_FLAG] = st_r.exit_flag;
			BLP_OFF_RESET_CAUSE: rd_byte = st_r.cause;
			BLP_OFF_BREAK_CLEAR: rd_byte[BLP_BIT_CLEAR_EN] = st_r.clear_en;
			BLP_OFF_CONFIG: begin
				rd_byte[BLP_BIT_WDOG_DIS] = st_r.wdog_dis;
				rd_byte[BLP_BIT_SHORT_REC] = st_r.short_rec;
			end
			default: rd_ok = 1'b0;
		endcase
		if (s_axi_araddr[31:4] != 28'h0000000) begin
			rd_ok = 1'b0;
			rd_byte = 8'h00;
		end
		case (st_r.aw_addr)
			BLP_OFF_BREAK_EXIT, BLP_OFF_RESET_CAUSE,
			BLP_OFF_BREAK_CLEAR, BLP_OFF_CONFIG: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	// ==========================================
	// next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.clr_mask = 1'b0;
		st_nxt.stack = 1'b0;
		// oscillator sampled twice; third stage finds the falling edge
		st_nxt.osc_sync = {st_r.osc_sync[1:0], osc_clk_pin};

		// bus channels
		if (s_axi_awvalid && s_axi_awready) begin
			st_nxt.aw_got = 1'b1;
			st_nxt.aw_addr = s_axi_awaddr[3:0];
			st_nxt.wr_en = (s_axi_awaddr[31:4] == 28'h0000000);
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_nxt.w_got = 1'b1;
			st_nxt.wdata = s_axi_wdata;
			// only byte lane 0 holds register bits; without it nothing changes
			st_nxt.wbyte = s_axi_wstrb[0];
		end
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (wr_fire) begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bad_wr = !(wr_ok && st_r.wr_en);
			if (wr_ok && st_r.wr_en && st_r.wbyte) begin
				case (st_r.aw_addr)
					BLP_OFF_BREAK_EXIT: begin
						if (!st_r.wdata[BLP_BIT_EXIT_FLAG]) begin
							st_nxt.exit_flag = 1'b0;
						end
					end
					BLP_OFF_BREAK_CLEAR: st_nxt.clear_en = st_r.wdata[BLP_BIT_CLEAR_EN];
					BLP_OFF_CONFIG: begin
						st_nxt.wdog_dis = st_r.wdata[BLP_BIT_WDOG_DIS];
						st_nxt.short_rec = st_r.wdata[BLP_BIT_SHORT_REC];
					end
					default: ;
				endcase
			end
		end
		if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (rd_fire) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = {24'h000000, rd_byte};
			st_nxt.rresp = rd_ok ? BLP_RESP_OKAY : BLP_RESP_SLVERR;
			if (rd_ok && rd_off == BLP_OFF_RESET_CAUSE) begin
				st_nxt.cause = 8'h00;
			end
		end

		// break entry and flag protection
		if (break_req && !st_r.brk) begin
			st_nxt.brk = 1'b1;
		end else if (!break_req) begin
			st_nxt.brk = 1'b0;
		end
		// low-power sequencing
		case (st_r.mode)
			BLP_RUN: begin
				if (stop_exec) begin
					st_nxt.mode = BLP_STOP;
					st_nxt.clr_mask = 1'b1;
				end else if (wait_exec) begin
					st_nxt.mode = BLP_WAIT;
					st_nxt.clr_mask = 1'b1;
				end
			end
			BLP_WAIT: begin
				if (break_req) begin
					st_nxt.mode = BLP_RUN;
					st_nxt.exit_flag = 1'b1;
				end else if (irq_pending) begin
					st_nxt.mode = BLP_RUN;
					st_nxt.stack = 1'b1;
				end
			end
			BLP_STOP: begin
				if (break_req) begin
					st_nxt.mode = BLP_RECOVER;
					st_nxt.exit_flag = 1'b1;
					st_nxt.rec_irq = 1'b0;
				end else if (irq_pending) begin
					st_nxt.mode = BLP_RECOVER;
					st_nxt.rec_irq = 1'b1;
				end
			end
			BLP_RECOVER: begin
				if (osc.osc_tick && osc.count == rec_last) begin
					st_nxt.mode = BLP_RUN;
					st_nxt.stack = st_r.rec_irq;
				end
			end
			default: st_nxt.mode = BLP_RUN;
		endcase

		// resets win over every interrupt path
		st_nxt.reset_out = any_reset;
		if (any_reset) begin
			st_nxt.mode = BLP_RUN;
			st_nxt.stack = 1'b0;
			st_nxt.cause = 8'h00;
			st_nxt.cause[BLP_CAUSE_PIN] = rst_pin;
			st_nxt.cause[BLP_CAUSE_WDOG] = rst_wdog & !st_r.wdog_dis;
			st_nxt.cause[BLP_CAUSE_OPC] = rst_opcode;
			st_nxt.cause[BLP_CAUSE_ADR] = rst_fetch;
			st_nxt.cause[BLP_CAUSE_LVD] = rst_lvd;
			if (rst_por) begin
				st_nxt.cause = BLP_RST_CAUSE;
			end
		end
	end

	// ==========================================
	// registers
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
			st_r.cause <= BLP_RST_CAUSE;
			st_r.clear_en <= BLP_RST_CLEAR_CTRL[BLP_BIT_CLEAR_EN];
			st_r.wdog_dis <= BLP_RST_CONFIG[BLP_BIT_WDOG_DIS];
			st_r.short_rec <= BLP_RST_CONFIG[BLP_BIT_SHORT_REC];
			st_r.mode <= BLP_RUN;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================
	// outputs
	// tick from oscillator falling edge; counter cleared through stop
	assign osc.osc_tick = (st_r.osc_sync[2:1] == 2'b10);
	assign osc.hold_clr = (st_r.mode == BLP_STOP);
	assign force_trap_vec = st_r.brk;
	assign in_break = st_r.brk;
	// a two-step clear begun before break is stopped at its second step only
	assign flag_clr_allow = !st_r.brk || st_r.clear_en;
	assign cpu_clk_en = (st_r.mode == BLP_RUN);
	assign periph_clk_en = (st_r.mode == BLP_RUN) || (st_r.mode == BLP_WAIT);
	assign bus_clk_en = (st_r.mode != BLP_STOP);
	assign osc_clk_en = (st_r.mode != BLP_STOP);
	assign clr_int_mask = st_r.clr_mask;
	assign stack_start = st_r.stack;
	assign wdog_en = !st_r.wdog_dis;
	assign sys_reset = st_r.reset_out;
	assign s_axi_awready = !st_r.aw_got;
	assign s_axi_wready = !st_r.w_got;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp = st_r.bad_wr ? BLP_RESP_SLVERR : BLP_RESP_OKAY;
	assign s_axi_arready = !st_r.rvalid;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rdata = st_r.rdata;
	assign s_axi_rresp = st_r.rresp;

	// ==========================================
	// checks
	a_wait_stacks: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(st_r.mode == BLP_WAIT && irq_pending && !break_req && !any_reset) |=> stack_start)
		else $error("wait wake missed");
	a_break_flag_wait: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(st_r.mode == BLP_WAIT && break_req && !any_reset) |=> st_r.exit_flag)
		else $error("break exit flag not set");
	a_stop_clocks: assert property (@(posedge clk_sys) disable iff (!arst_n)
		st_r.mode == BLP_STOP |-> (!bus_clk_en && !osc_clk_en && !cpu_clk_en))
		else $error("clocks run in stop");
	a_wait_clocks: assert property (@(posedge clk_sys) disable iff (!arst_n)
		st_r.mode == BLP_WAIT |-> (!cpu_clk_en && periph_clk_en && bus_clk_en))
		else $error("wrong clocks in wait");
	a_protect_flags: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(in_break && !st_r.clear_en) |-> !flag_clr_allow) else $error("flags unprotected");
	a_step_blocked: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(in_break && !st_r.clear_en && flag_clr_req) |-> !flag_clr_allow)
		else $error("clear step passed in break");
	a_break_ends: assert property (@(posedge clk_sys) disable iff (!arst_n)
		$fell(in_break) |-> flag_clr_allow) else $error("flags locked after break");
	a_break_enters: assert property (@(posedge clk_sys) disable iff (!arst_n)
		break_req |=> force_trap_vec) else $error("break not entered");
	a_enter_mask: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(st_r.mode == BLP_RUN && (wait_exec || stop_exec) && !any_reset) |=> clr_int_mask)
		else $error("mask not cleared");
	a_reset_wins: assert property (@(posedge clk_sys) disable iff (!arst_n)
		any_reset |=> (!stack_start && cpu_clk_en)) else $error("reset lost to irq");
	a_por_cause: assert property (@(posedge clk_sys) disable iff (!arst_n)
		rst_por |=> (st_r.cause == BLP_RST_CAUSE)) else $error("por cause wrong");
	a_cause_read: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(rd_fire && rd_ok && rd_off == BLP_OFF_RESET_CAUSE && !any_reset)
		|=> (st_r.cause == 8'h00)) else $error("cause not cleared by read");
	a_stop_recover: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(st_r.mode == BLP_STOP) |-> !stack_start) else $error("stacking before recovery");
	a_recover_ends: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(st_r.mode == BLP_RECOVER && osc.osc_tick && osc.count == rec_last && !any_reset)
		|=> (cpu_clk_en && stack_start == st_r.rec_irq)) else $error("recovery end wrong");
	a_recover_early: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(st_r.mode == BLP_RECOVER && !(osc.osc_tick && osc.count == rec_last))
		|=> !stack_start) else $error("stacking before recovery end");
endmodule // blp_break_lowpower

// [blp_cpu_model.sv]
`timescale 1ns/100ps
// ==========================================
// cpu core and break module as seen by the sequencer
module blp_cpu_model (
	input wire logic clk_sys, // system clock
	input wire logic arst_n, // async reset, low
	input wire logic [1:0] cmd, // 1 wait, 2 stop, one cycle
	input wire logic brk, // break wanted, level
	input wire logic irq, // interrupt wanted, level
	input wire logic cpu_clk_en, // cpu clocked
	output logic wait_exec, // wait executed, pulse
	output logic stop_exec, // stop executed, pulse
	output logic break_req, // break request, level
	output logic irq_pending // enabled interrupt, level
);
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wait_exec <= 1'b0;
			stop_exec <= 1'b0;
			break_req <= 1'b0;
			irq_pending <= 1'b0;
		end else begin
			// an unclocked cpu executes nothing
			wait_exec <= cpu_clk_en && cmd == 2'd1;
			stop_exec <= cpu_clk_en && cmd == 2'd2;
			break_req <= brk;
			irq_pending <= irq;
		end
	end
endmodule // blp_cpu_model

// [blp_break_lowpower_tb.sv]
`timescale 1ns/100ps
module blp_break_lowpower_tb;
	import blp_pkg::*;
	localparam int OSC_HALF_NS = 19;
	// recovery in system cycles: oscillator periods over the 5 ns clock
	localparam int REC_SHORT_SYS = BLP_REC_SHORT_CYC * 2 * OSC_HALF_NS / 5;
	localparam int REC_LONG_SYS = BLP_REC_LONG_CYC * 2 * OSC_HALF_NS / 5;
	logic clk_sys, arst_n, osc, flag_clr_req, brk, irq;
	logic [1:0] cmd;
	logic [5:0] rs;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic wait_exec, stop_exec, break_req, irq_pending, force_trap_vec, in_break;
	logic flag_clr_allow, cpu_clk_en, bus_clk_en, osc_clk_en, periph_clk_en;
	logic clr_int_mask, stack_start, wdog_en, sys_reset;
	int fails, check_count, cyc, n_clr, n_stk, t_stk;
	int cause_bit [6] = '{BLP_CAUSE_POR, BLP_CAUSE_PIN, BLP_CAUSE_WDOG, BLP_CAUSE_OPC,
		BLP_CAUSE_ADR, BLP_CAUSE_LVD};

	blp_cpu_model CPU (.clk_sys, .arst_n, .cmd, .brk, .irq, .cpu_clk_en, .wait_exec,
		.stop_exec, .break_req, .irq_pending);
	blp_break_lowpower DUT (.clk_sys, .arst_n, .osc_clk_pin(osc), .break_req, .wait_exec,
		.stop_exec, .irq_pending, .rst_por(rs[0]), .rst_pin(rs[1]), .rst_wdog(rs[2]),
		.rst_opcode(rs[3]), .rst_fetch(rs[4]), .rst_lvd(rs[5]), .flag_clr_req, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .force_trap_vec, .in_break, .flag_clr_allow, .cpu_clk_en, .bus_clk_en,
		.osc_clk_en, .periph_clk_en, .clr_int_mask, .stack_start, .wdog_en, .sys_reset);

	// ==========================================
	// clocks and event counters
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// oscillator stalls while its output is gated
	initial begin
		osc = 1'b0;
		forever #OSC_HALF_NS if (osc_clk_en !== 1'b0) osc = ~osc;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (clr_int_mask === 1'b1) n_clr <= n_clr + 1;
		if (stack_start === 1'b1) begin
			n_stk <= n_stk + 1;
			t_stk <= cyc;
		end
	end

	// ==========================================
	// compare and bus tasks
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] er);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// no assumed latency; only the watchdog ends a hung wait
		do begin
			@(posedge clk_sys);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
	endtask
	task automatic rc(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
		chk("rdata", e, s_axi_rdata);
	endtask
	task automatic op(input logic [1:0] c);
		@(posedge clk_sys);
		cmd <= c;
		@(posedge clk_sys);
		cmd <= 2'd0;
		repeat (4) @(posedge clk_sys);
	endtask
	// raise an interrupt and time the stacking pulse
	task automatic wake(input int lo, input int hi);
		int k, t0, n;
		@(posedge clk_sys);
		k = n_stk;
		t0 = cyc;
		irq <= 1'b1;
		for (n = 0; n < hi + 20 && n_stk == k; n++) @(posedge clk_sys);
		irq <= 1'b0;
		chk("wake_delay", 1, t_stk - t0 >= lo && t_stk - t0 <= hi && n_stk == k + 1);
		chk("cpu_clk_back", 1, cpu_clk_en);
	endtask
	task automatic end_of_test;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		#400000;
		fails++;
		end_of_test();
	end

	// ==========================================
	// tests
	initial begin
		{arst_n, flag_clr_req, brk, irq, cmd, rs, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_wdata} = '0;
		{cyc, n_clr, n_stk, t_stk, fails, check_count} = '0;
		s_axi_araddr = '0;
		s_axi_wstrb = 4'hf;
		repeat (10) @(posedge clk_sys);
		arst_n <= 1'b1;
		rc(32'h4, {24'h0, BLP_RST_CAUSE}, BLP_RESP_OKAY);
		rc(32'h4, 32'h0, BLP_RESP_OKAY);
		rc(32'h8, 32'h0, BLP_RESP_OKAY);
		rc(32'h10, 32'h0, BLP_RESP_SLVERR);
		wr(32'h14, 32'hff, BLP_RESP_SLVERR);
		s_axi_wstrb <= 4'h0;
		wr(32'h8, 32'h80, BLP_RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		rc(32'h8, 32'h0, BLP_RESP_OKAY);
		chk("clr_allow_idle", 1, flag_clr_allow);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk_sys);
			rs <= 6'h1 << i;
			@(posedge clk_sys);
			rs <= 6'h0;
			#1;
			chk("sys_reset", 1, sys_reset);
			rc(32'h4, 32'h1 << cause_bit[i], BLP_RESP_OKAY);
			rc(32'h4, 32'h0, BLP_RESP_OKAY);
		end
		op(2'd1);
		chk("wait_cpu_clk", 0, cpu_clk_en);
		chk("wait_periph_clk", 1, periph_clk_en);
		chk("wait_bus_clk", 1, bus_clk_en);
		chk("wait_wdog", 1, wdog_en);
		chk("mask_clears", 1, n_clr);
		wake(1, 4);
		op(2'd1);
		brk <= 1'b1;
		flag_clr_req <= 1'b1;
		repeat (4) @(posedge clk_sys);
		chk("break_wakes_wait", 1, cpu_clk_en);
		chk("trap_vec", 1, force_trap_vec);
		chk("in_break", 1, in_break);
		chk("clr_blocked", 0, flag_clr_allow);
		rc(32'h0, 32'h2, BLP_RESP_OKAY);
		rc(32'h10, 32'h0, BLP_RESP_SLVERR);
		wr(32'h8, 32'h80, BLP_RESP_OKAY);
		rc(32'h8, 32'h80, BLP_RESP_OKAY);
		chk("clr_enabled", 1, flag_clr_allow);
		wr(32'h8, 32'h0, BLP_RESP_OKAY);
		chk("clr_blocked_again", 0, flag_clr_allow);
		brk <= 1'b0;
		flag_clr_req <= 1'b0;
		repeat (4) @(posedge clk_sys);
		chk("clr_after_break", 1, flag_clr_allow);
		chk("trap_released", 0, force_trap_vec);
		wr(32'h0, 32'h0, BLP_RESP_OKAY);
		rc(32'h0, 32'h0, BLP_RESP_OKAY);
		wr(32'hc, 32'h2, BLP_RESP_OKAY);
		op(2'd2);
		chk("stop_bus_clk", 0, bus_clk_en);
		chk("stop_osc_clk", 0, osc_clk_en);
		chk("stop_periph_clk", 0, periph_clk_en);
		chk("stop_cpu_clk", 0, cpu_clk_en);
		wake(REC_SHORT_SYS - 8, REC_SHORT_SYS + 12);
		op(2'd2);
		brk <= 1'b1;
		// a break out of stop still counts out the recovery
		repeat (REC_SHORT_SYS + 40) @(posedge clk_sys);
		chk("break_ends_stop", 1, cpu_clk_en);
		rc(32'h0, 32'h2, BLP_RESP_OKAY);
		brk <= 1'b0;
		wr(32'h0, 32'h0, BLP_RESP_OKAY);
		wr(32'hc, 32'h0, BLP_RESP_OKAY);
		op(2'd2);
		wake(REC_LONG_SYS - 8, REC_LONG_SYS + 12);
		chk("mask_count", 5, n_clr);
		wr(32'hc, 32'h1, BLP_RESP_OKAY);
		repeat (2) @(posedge clk_sys);
		chk("wdog_disabled", 0, wdog_en);
		end_of_test();
	end
endmodule // blp_break_lowpower_tb
